// *** dcw_map.svh ***
// Offsets, field positions and reset values of the control word
`ifndef DCW_MAP_SVH
`define DCW_MAP_SVH
`define DCW_CTL_ONE_ADDR  8'h00
`define DCW_CTL_ONE_RST   32'h00000000
`define DCW_USE_INT_BIT   27
`define DCW_PROF_HI       22
`define DCW_PROF_LO       20
`define DCW_SYNC_DIS_BIT  19
`define DCW_DSW_BIT       16
`define DCW_AUX_CLR_BIT   15
`define DCW_PH_CLR_BIT    14
`define DCW_DEST_HI       13
`define DCW_DEST_LO       12
`define DCW_AUX_EN_BIT    11
`define DCW_DC_BIT        10
`define DCW_TRIG_BIT      9
`define DCW_NODWELL_BIT   8
`define DCW_PD_MODE_BIT   7
`endif

// *** dcw_pkg.sv ***
// Types shared by the control word decoder
package dcw_pkg;
	typedef enum logic [1:0] {
		DCW_DEST_FREQ  = 2'h0,
		DCW_DEST_PHASE = 2'h1
	} dcw_dest_t;
endpackage

// *** dcw_ctrl.sv ***
// Control word bits 27:7: buffer, update commit and decode
`timescale 1ns/10ps
`include "dcw_map.svh"
module dcw_ctrl #(
	parameter int SYNC_HALF = 2 // System clocks per sync half period
) (
	input  wire logic        i_clk,             // System clock 40 MHz
	input  wire logic        i_sys_rst,         // Async reset, high
	input  wire logic        i_wr_en,           // Port write strobe
	input  wire logic [7:0]  i_wr_addr,         // Port write address
	input  wire logic [31:0] i_wr_data,         // Port write data
	input  wire logic [7:0]  i_rd_addr,         // Port read address
	input  wire logic        i_io_update,       // Update pin, async
	input  wire logic [2:0]  i_profile_pins,    // Profile pins, async
	input  wire logic        i_ext_pd,          // Power-down pin, async
	input  wire logic        i_linear_sweep_en, // Sweep enabled
	output logic [31:0]      o_rd_data,         // Buffer readback
	output logic [2:0]       o_profile_sel,     // Active profile
	output logic             o_sync_clk,        // Sync clock pin
	output logic             o_direct_switch,   // Direct switch on
	output logic             o_aux_acc_clear,   // Ramp acc reset
	output logic             o_phase_acc_clear, // Phase acc reset
	output dcw_pkg::dcw_dest_t o_dest,          // Switch/sweep target
	output logic             o_aux_acc_run,     // Ramp acc runs
	output logic             o_dc_output,       // DAC full-scale
	output logic             o_state_trigger,   // 1 state, 0 edge
	output logic             o_no_dwell,        // Return to start
	output logic             o_pd_digital,      // Core and DAC logic off
	output logic             o_pd_analog        // Bias, PLL, osc off
);

	logic [31:0] shadow_ff, nxt_shadow;
	logic [31:0] active_ff, nxt_active;
	logic [31:0] rd_ff, nxt_rd;
	logic [2:0]  upd_sync_ff, nxt_upd_sync;
	logic [2:0]  prf_s1_ff, prf_s2_ff;
	logic [1:0]  pd_sync_ff;
	logic [2:0]  prof_ff, nxt_prof;
	logic        pend_ff, nxt_pend;
	logic [7:0]  cnt_ff, nxt_cnt;
	logic        sclk_ff, nxt_sclk;
	logic        aux_ff, nxt_aux;
	logic        dsw_ff, nxt_dsw;
	logic        phc_ff, nxt_phc;
	logic [1:0]  dest_ff, nxt_dest;
	logic        run_ff, nxt_run;
	logic        dc_ff, nxt_dc;
	logic        trg_ff, nxt_trg;
	logic        ndw_ff, nxt_ndw;
	logic        pdd_ff, nxt_pdd;
	logic        pda_ff, nxt_pda;
	logic        upd;
	logic        sync_rise;
	logic        prof_chg;
	logic [2:0]  prof_now;

	// Pin synchronisers, second stage feeds logic
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prf_s1_ff  <= 3'h0;
			prf_s2_ff  <= 3'h0;
			pd_sync_ff <= 2'h0;
		end else begin
			prf_s1_ff  <= i_profile_pins;
			prf_s2_ff  <= prf_s1_ff;
			pd_sync_ff <= {pd_sync_ff[0], i_ext_pd};
		end
	end

	// Write buffer, commit and sync clock next values
	always_comb begin
		nxt_upd_sync = {upd_sync_ff[1:0], i_io_update};
		upd = upd_sync_ff[1] & ~upd_sync_ff[2];
		nxt_shadow = shadow_ff;
		if (i_wr_en && i_wr_addr == `DCW_CTL_ONE_ADDR) begin
			nxt_shadow = i_wr_data;
		end
		nxt_rd = 32'h00000000;
		if (i_rd_addr == `DCW_CTL_ONE_ADDR) begin
			nxt_rd = shadow_ff;
		end
		nxt_active = upd ? shadow_ff : active_ff;
		prof_now = active_ff[`DCW_USE_INT_BIT] ?
			active_ff[`DCW_PROF_HI:`DCW_PROF_LO] : prf_s2_ff;
		nxt_prof = prof_now;
		prof_chg = prof_now != prof_ff;
		nxt_cnt  = 8'h00;
		nxt_sclk = 1'b0;
		sync_rise = 1'b0;
		if (!active_ff[`DCW_SYNC_DIS_BIT]) begin
			nxt_sclk = sclk_ff;
			nxt_cnt  = cnt_ff + 8'h01;
			if (cnt_ff == 8'(SYNC_HALF - 1)) begin
				nxt_cnt   = 8'h00;
				nxt_sclk  = ~sclk_ff;
				sync_rise = ~sclk_ff;
			end
		end
		nxt_pend = (pend_ff & ~sync_rise) | upd | prof_chg;
		nxt_aux  = aux_ff;
		if (pend_ff && sync_rise) begin
			nxt_aux = active_ff[`DCW_AUX_CLR_BIT];
		end
	end

	// Registers for buffer, commit and sync clock
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			upd_sync_ff <= 3'h0;
			shadow_ff   <= `DCW_CTL_ONE_RST;
			active_ff   <= `DCW_CTL_ONE_RST;
			rd_ff       <= 32'h00000000;
			prof_ff     <= 3'h0;
			cnt_ff      <= 8'h00;
			sclk_ff     <= 1'b0;
			pend_ff     <= 1'b0;
			aux_ff      <= 1'b0;
		end else begin
			upd_sync_ff <= nxt_upd_sync;
			shadow_ff   <= nxt_shadow;
			active_ff   <= nxt_active;
			rd_ff       <= nxt_rd;
			prof_ff     <= nxt_prof;
			cnt_ff      <= nxt_cnt;
			sclk_ff     <= nxt_sclk;
			pend_ff     <= nxt_pend;
			aux_ff      <= nxt_aux;
		end
	end

	// Decode of committed bits and power-down pin to controls
	always_comb begin
		nxt_dsw  = active_ff[`DCW_DSW_BIT];
		nxt_phc  = active_ff[`DCW_PH_CLR_BIT];
		nxt_dest = active_ff[`DCW_DEST_HI:`DCW_DEST_LO];
		nxt_run  = i_linear_sweep_en & active_ff[`DCW_AUX_EN_BIT];
		nxt_dc   = active_ff[`DCW_DC_BIT];
		nxt_trg  = active_ff[`DCW_TRIG_BIT];
		nxt_ndw  = i_linear_sweep_en & active_ff[`DCW_NODWELL_BIT];
		nxt_pdd  = pd_sync_ff[1];
		nxt_pda  = pd_sync_ff[1] & active_ff[`DCW_PD_MODE_BIT];
	end

	// Decoded control registers
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dsw_ff  <= 1'b0;
			phc_ff  <= 1'b0;
			dest_ff <= 2'h0;
			run_ff  <= 1'b0;
			dc_ff   <= 1'b0;
			trg_ff  <= 1'b0;
			ndw_ff  <= 1'b0;
			pdd_ff  <= 1'b0;
			pda_ff  <= 1'b0;
		end else begin
			dsw_ff  <= nxt_dsw;
			phc_ff  <= nxt_phc;
			dest_ff <= nxt_dest;
			run_ff  <= nxt_run;
			dc_ff   <= nxt_dc;
			trg_ff  <= nxt_trg;
			ndw_ff  <= nxt_ndw;
			pdd_ff  <= nxt_pdd;
			pda_ff  <= nxt_pda;
		end
	end

	// Outputs straight from flops
	assign o_rd_data         = rd_ff;
	assign o_profile_sel     = prof_ff;
	assign o_sync_clk        = sclk_ff;
	assign o_direct_switch   = dsw_ff;
	assign o_aux_acc_clear   = aux_ff;
	assign o_phase_acc_clear = phc_ff;
	assign o_dest            = dcw_pkg::dcw_dest_t'(dest_ff);
	assign o_aux_acc_run     = run_ff;
	assign o_dc_output       = dc_ff;
	assign o_state_trigger   = trg_ff;
	assign o_no_dwell        = ndw_ff;
	assign o_pd_digital      = pdd_ff;
	assign o_pd_analog       = pda_ff;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_commit;
		upd |=> active_ff == $past(shadow_ff);
	endproperty
	a_commit: assert property (p_commit)
		else $error("update did not commit buffer");

	property p_hold;
		!upd |=> $stable(active_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("active word changed without update");

	property p_dsw;
		upd |-> ##2
			o_direct_switch == $past(shadow_ff[`DCW_DSW_BIT], 2);
	endproperty
	a_dsw: assert property (p_dsw)
		else $error("direct switch not from committed bit");

	property p_phc;
		upd |-> ##2
			o_phase_acc_clear == $past(shadow_ff[`DCW_PH_CLR_BIT], 2);
	endproperty
	a_phc: assert property (p_phc)
		else $error("phase clear not from committed bit");

	property p_sync_off;
		$past(active_ff[`DCW_SYNC_DIS_BIT]) |-> !o_sync_clk;
	endproperty
	a_sync_off: assert property (p_sync_off)
		else $error("sync clock not low while disabled");

	property p_aux_apply;
		pend_ff && sync_rise |=>
			o_aux_acc_clear == $past(active_ff[`DCW_AUX_CLR_BIT]);
	endproperty
	a_aux_apply: assert property (p_aux_apply)
		else $error("aux clear not applied at sync edge");

	property p_aux_wait;
		!(pend_ff && sync_rise) |=> $stable(o_aux_acc_clear);
	endproperty
	a_aux_wait: assert property (p_aux_wait)
		else $error("aux clear changed off sync edge");

	property p_prof;
		$past(active_ff[`DCW_USE_INT_BIT]) |->
			o_profile_sel == $past(active_ff[`DCW_PROF_HI:`DCW_PROF_LO]);
	endproperty
	a_prof: assert property (p_prof)
		else $error("internal profile not followed");

	property p_run;
		!$past(i_linear_sweep_en) |-> !o_aux_acc_run && !o_no_dwell;
	endproperty
	a_run: assert property (p_run)
		else $error("sweep bits acted without sweep");

	property p_pd;
		o_pd_analog |-> o_pd_digital && $past(active_ff[`DCW_PD_MODE_BIT]);
	endproperty
	a_pd: assert property (p_pd)
		else $error("full power-down without mode bit");

	property p_dest;
		upd |-> ##2
			o_dest == $past(shadow_ff[`DCW_DEST_HI:`DCW_DEST_LO], 2);
	endproperty
	a_dest: assert property (p_dest)
		else $error("destination not from committed field");

	property p_dc;
		upd |-> ##2 o_dc_output == $past(shadow_ff[`DCW_DC_BIT], 2);
	endproperty
	a_dc: assert property (p_dc)
		else $error("full-scale output not from committed bit");

	property p_trg;
		upd |-> ##2 o_state_trigger == $past(shadow_ff[`DCW_TRIG_BIT], 2);
	endproperty
	a_trg: assert property (p_trg)
		else $error("trigger style not from committed bit");

	property p_ndw;
		$past(i_linear_sweep_en) |->
			o_no_dwell == $past(active_ff[`DCW_NODWELL_BIT]);
	endproperty
	a_ndw: assert property (p_ndw)
		else $error("no-dwell not from committed bit");

	property p_pd_fast;
		o_pd_digital == $past(pd_sync_ff[1]);
	endproperty
	a_pd_fast: assert property (p_pd_fast)
		else $error("digital power-down not following pin");

	property p_prof_pins;
		!$past(active_ff[`DCW_USE_INT_BIT]) |->
			o_profile_sel == $past(prf_s2_ff);
	endproperty
	a_prof_pins: assert property (p_prof_pins)
		else $error("profile field acted without internal use");

	property p_cv_upd;
		upd ##2 o_dc_output;
	endproperty
	c_upd: cover property (p_cv_upd);

	property p_cv_aux;
		pend_ff && sync_rise ##1 o_aux_acc_clear;
	endproperty
	c_aux: cover property (p_cv_aux);

	property p_cv_pd;
		o_pd_analog;
	endproperty
	c_pd: cover property (p_cv_pd);

	property p_cv_prof;
		active_ff[`DCW_USE_INT_BIT] ##1 o_profile_sel == 3'h3;
	endproperty
	c_prof: cover property (p_cv_prof);

	property p_cv_sweep;
		o_aux_acc_run && o_no_dwell;
	endproperty
	c_sweep: cover property (p_cv_sweep);

endmodule

// *** dcw_host_model.sv ***
// Host model that writes the control word and pulses update
`timescale 1ns/10ps
module dcw_host_model (
	input  wire logic        i_clk,       // System clock
	output logic             o_wr_en,     // Write strobe
	output logic [7:0]       o_wr_addr,   // Write address
	output logic [31:0]      o_wr_data,   // Write data
	output logic             o_io_update  // Update pin
);
	initial begin
		o_wr_en = 1'b0;
		o_wr_addr = 8'h00;
		o_wr_data = 32'h00000000;
		o_io_update = 1'b0;
	end
	// One write; lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] w;
		w = d & ~32'h00060000;
		if (w[28]) begin
			w[13:12] = 2'h0;
		end
		@(negedge i_clk);
		o_wr_addr = a;
		o_wr_data = w;
		o_wr_en = 1'b1;
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_wr_addr = ~a;
		o_wr_data = ~d;
	endtask
	// Update pulse, low again before the next one
	task automatic upd();
		@(negedge i_clk);
		o_io_update = 1'b1;
		repeat (2) @(negedge i_clk);
		o_io_update = 1'b0;
	endtask
endmodule

// *** dcw_ctrl_tb_top.sv ***
// Self-checking bench for the control word decoder
`timescale 1ns/10ps
module dcw_ctrl_tb_top;
	logic clk = 1'b0, rst = 1'b1, wr_en, upd, pd = 1'b0, sw = 1'b0;
	logic [7:0]  wr_addr, rd_addr = 8'h00;
	logic [31:0] wr_data, rd;
	logic [2:0]  pins = 3'h0, prof;
	logic        sclk, dsw, auxc, phc, run, dc, trig, ndw, pdd, pda;
	dcw_pkg::dcw_dest_t dest;
	int miscompares = 0, tests_run = 0, n;
	always #12.5 clk = ~clk;
	dcw_host_model dcw_host_model_inst (.i_clk(clk), .o_wr_en(wr_en),
		.o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_io_update(upd));
	dcw_ctrl dcw_ctrl_inst (.i_clk(clk), .i_sys_rst(rst), .i_wr_en(wr_en),
		.i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
		.i_io_update(upd), .i_profile_pins(pins), .i_ext_pd(pd),
		.i_linear_sweep_en(sw), .o_rd_data(rd), .o_profile_sel(prof),
		.o_sync_clk(sclk), .o_direct_switch(dsw), .o_aux_acc_clear(auxc),
		.o_phase_acc_clear(phc), .o_dest(dest), .o_aux_acc_run(run),
		.o_dc_output(dc), .o_state_trigger(trig), .o_no_dwell(ndw),
		.o_pd_digital(pdd), .o_pd_analog(pda));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cfg(input logic [31:0] w);
		dcw_host_model_inst.wr(8'h00, w);
		dcw_host_model_inst.upd();
		repeat (12) @(negedge clk);
	endtask
	task automatic waitn(input int c);
		repeat (c) @(negedge clk);
	endtask
	// Count sync clock transitions over 16 cycles
	task automatic edges(output int c);
		logic p;
		c = 0;
		p = sclk;
		repeat (16) begin
			@(negedge clk);
			if (sclk !== p) c++;
			p = sclk;
		end
	endtask
	task automatic t_reset();
		chk("outs", {prof, sclk, dsw, auxc, phc, dest, run, dc, trig, ndw,
			pdd, pda}, 0);
		chk("rd_reset", rd, 0);
		dcw_host_model_inst.wr(8'h00, 32'h00010000);
		dcw_host_model_inst.wr(8'h04, 32'hFFFFFFFF);
		waitn(6);
		chk("rd", rd, 32'h00010000);
		chk("dsw", dsw, 1'b0);
		rd_addr = 8'h04;
		waitn(3);
		chk("rd_unmapped", rd, 0);
		rd_addr = 8'h00;
		$display("test reset done");
	endtask
	task automatic t_modes();
		cfg(32'h00015F00);
		chk("dsw", dsw, 1'b1);
		chk("phc", phc, 1'b1);
		chk("dest", dest, dcw_pkg::DCW_DEST_PHASE);
		chk("run", run, 1'b0);
		chk("ndw", ndw, 1'b0);
		chk("dc", dc, 1'b1);
		chk("trig", trig, 1'b1);
		sw = 1'b1;
		waitn(3);
		chk("run", run, 1'b1);
		chk("ndw", ndw, 1'b1);
		cfg(32'h10003000);
		chk("rd", rd, 32'h10000000);
		chk("dest", dest, dcw_pkg::DCW_DEST_FREQ);
		cfg(32'h00000000);
		chk("dest", dest, dcw_pkg::DCW_DEST_FREQ);
		chk("modes", {dsw, phc, run, dc, trig, ndw}, 0);
		$display("test modes done");
	endtask
	task automatic t_profile();
		pins = 3'h5;
		waitn(5);
		chk("prof", prof, 3'h5);
		cfg(32'h08300000);
		chk("prof", prof, 3'h3);
		pins = 3'h2;
		waitn(5);
		chk("prof", prof, 3'h3);
		cfg(32'h00300000);
		chk("prof", prof, 3'h2);
		$display("test profile done");
	endtask
	task automatic t_pd();
		pd = 1'b1;
		waitn(4);
		chk("pd", {pdd, pda}, 2'h2);
		cfg(32'h00000080);
		chk("pd", {pdd, pda}, 2'h3);
		pd = 1'b0;
		waitn(4);
		chk("pd", {pdd, pda}, 2'h0);
		$display("test power down done");
	endtask
	task automatic t_sync();
		cfg(32'h00008000);
		chk("auxc", auxc, 1'b1);
		edges(n);
		chk("sync_edges", n, 8);
		dcw_host_model_inst.wr(8'h00, 32'h00000000);
		waitn(12);
		chk("auxc", auxc, 1'b1);
		dcw_host_model_inst.upd();
		waitn(12);
		chk("auxc", auxc, 1'b0);
		cfg(32'h00080000);
		edges(n);
		chk("sync_edges", n, 0);
		chk("sclk", sclk, 1'b0);
		$display("test sync done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_modes();
		t_profile();
		t_pd();
		t_sync();
		stop_test();
	end
endmodule
